// ==== rtl/sar_link_pkg.sv ====
// Shared constants and types for the serial converter control block
package sar_link_pkg;

    // Sequencer states, one-hot
    typedef enum logic [4:0] {
        ST_IDLE    = 5'h01,   // Waiting for the start bit
        ST_ADDR    = 5'h02,   // Shifting the assignment word
        ST_SETTLE  = 5'h04,   // Multiplexer settling period
        ST_CONVERT = 5'h08,   // Successive approximation, MSB first
        ST_LSBOUT  = 5'h10    // Result replay, LSB first
    } adc_state_t;

    // Source of the negative multiplexer terminal
    localparam logic [1:0] NEG_CHANNEL = 2'h0;   // Adjacent input of the pair
    localparam logic [1:0] NEG_COMMON  = 2'h1;   // Shared common input
    localparam logic [1:0] NEG_GROUND  = 2'h2;   // Analog ground

    // Word sizes and counts
    localparam int unsigned RESULT_BITS   = 8;   // Result code width
    localparam int unsigned OUT_SREG_BITS = 9;   // Output shift register width
    localparam logic [2:0]  ADDR_BITS_4IN = 3'h3; // Assignment word, 4-input
    localparam logic [2:0]  ADDR_BITS_8IN = 3'h4; // Assignment word, 8-input
    localparam logic [3:0]  LAST_BIT_CNT  = 4'h7; // Index of the final decision
    localparam int unsigned FIFO_WORDS    = 32;  // Result buffer depth

    // Values after reset and start values
    localparam logic [7:0] TRIAL_START  = 8'h80; // First trial code, MSB set
    localparam logic [7:0] CODE_ZERO    = 8'h00; // Cleared result
    localparam logic [2:0] CNT3_ZERO    = 3'h0;  // Cleared 3-bit counter
    localparam logic [3:0] CNT4_ZERO    = 4'h0;  // Cleared 4-bit counter
    localparam logic [3:0] WORD_ZERO    = 4'h0;  // Cleared assignment word
    localparam logic [8:0] SREG_ZERO    = 9'h000; // Cleared output register

endpackage : sar_link_pkg

// ==== rtl/result_fifo.sv ====
// Result buffer with valid/ready on both sides
`timescale 1ns/10ps
module result_fifo #(
    parameter int unsigned WIDTH = 8,     // Word width
    parameter int unsigned DEPTH = 32     // Word count
) (
    // Clock and reset
    input  wire logic             clock_in,
    input  wire logic             rst_n_in,
    // Filling side
    input  wire logic [WIDTH-1:0] wr_data_in,
    input  wire logic             wr_valid_in,
    output logic                  wr_ready_out,
    // Draining side
    output logic      [WIDTH-1:0] rd_data_out,
    output logic                  rd_valid_out,
    input  wire logic             rd_ready_in
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];     // Storage array
    logic [AW-1:0]    wr_ptr_reg;      // Next write slot
    logic [AW-1:0]    rd_ptr_reg;      // Next read slot
    logic [AW:0]      count_reg;       // Words held
    logic             do_wr;           // Accepted write
    logic             do_rd;           // Accepted read

    // Flags come from the count so full and empty are exact
    assign wr_ready_out = (count_reg != DEPTH[AW:0]);
    assign rd_valid_out = (count_reg != '0);
    assign rd_data_out  = mem[rd_ptr_reg];
    assign do_wr        = wr_valid_in && wr_ready_out;
    assign do_rd        = rd_valid_out && rd_ready_in;

    // Pointers and count
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (do_rd) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end

    // Storage has no reset; only written slots are ever read
    always_ff @(posedge clock_in) begin
        if (do_wr) begin
            mem[wr_ptr_reg] <= wr_data_in;
        end
    end

endmodule : result_fifo

// ==== rtl/serial_sar_adc_interface.sv ====
// Serial control, multiplexer addressing and SAR sequencing of an 8-bit converter
`timescale 1ns/10ps
module serial_sar_adc_interface
    import sar_link_pkg::*;
#(
    parameter bit EIGHT_INPUT = 1'b1   // 1: 8-input variant, 0: 4-input variant
) (
    // System clock and reset
    input  wire logic       clock_in,
    input  wire logic       rst_n_in,
    // Serial link pins
    input  wire logic       chip_select_n_in,
    input  wire logic       serial_clk_in,
    input  wire logic       serial_in_in,
    input  wire logic       lsb_shift_enable_n_in,
    output logic            serial_out_out,
    output logic            serial_out_oe_n_out,
    output logic            conversion_active_out,
    output logic            conversion_active_oe_n_out,
    // Analog front end
    input  wire logic       comparator_in,
    output logic [7:0]      dac_code_out,
    output logic            mux_enable_out,
    output logic [2:0]      pos_channel_out,
    output logic [2:0]      neg_channel_out,
    output logic [1:0]      neg_mode_out,
    // Result stream
    output logic [7:0]      result_data_out,
    output logic            result_valid_out,
    input  wire logic       result_ready_in
);

    // Whole state of the block apart from the result buffer in one record
    typedef struct packed {
        adc_state_t  state;        // Sequencer
        logic [1:0]  cs_sync;      // Select synchroniser
        logic [2:0]  sclk_sync;    // Link clock synchroniser plus edge stage
        logic [1:0]  din_sync;     // Serial input synchroniser
        logic [1:0]  se_sync;      // Shift control synchroniser
        logic [1:0]  cmp_sync;     // Comparator synchroniser
        logic [2:0]  addr_cnt;     // Address bits taken
        logic [3:0]  addr_word;    // Address shift register
        logic [2:0]  pos_ch;       // Positive input
        logic [2:0]  neg_ch;       // Negative input
        logic [1:0]  neg_mode;     // Negative terminal source
        logic        mux_en;       // Multiplexer connected
        logic [7:0]  trial;        // Approximation register
        logic [7:0]  mask;         // Bit under test
        logic [3:0]  bit_cnt;      // Decisions made
        logic [8:0]  out_sreg;     // Output shift register
        logic        dout;         // Serial output level
        logic        dout_oe_n;    // Serial output enable, low drives
        logic        conversion_active;         // Conversion active
        logic        push;         // Result write strobe
        logic [7:0]  push_data;    // Result word
    } adc_regs_t;

    localparam logic [2:0] ADDR_LAST = (EIGHT_INPUT ? ADDR_BITS_8IN : ADDR_BITS_4IN) - 3'h1;

    adc_regs_t st_reg;      // Registered state
    adc_regs_t st_next;     // Next state
    logic      fifo_ready;  // Buffer can take a word
    logic      sclk_rise;   // Link clock rising edge
    logic      sclk_fall;   // Link clock falling edge
    logic      cs_high;     // Select released

    // Assignment word to multiplexer routing
    function automatic logic [7:0] decode_mux(input logic [3:0] word);
        logic       single;
        logic       odd;
        logic [1:0] sel;
        logic [7:0] res;
        single = 1'b0;
        odd    = 1'b0;
        sel    = 2'h0;
        res    = 8'h00;
        if (EIGHT_INPUT) begin
            single = word[3];
            odd    = word[2];
            sel    = word[1:0];
        end else begin
            single = word[2];
            odd    = word[1];
            sel    = {1'b0, word[0]};             // High select bit forced low inside
        end
        // Positive input is twice the pair index plus odd/even
        res[7:5] = {sel, odd};
        if (single) begin
            res[4:2] = {sel, odd};
            // Common is the negative leg on 8-input, ground on 4-input
            res[1:0] = EIGHT_INPUT ? NEG_COMMON : NEG_GROUND;
        end else begin
            // Partner of the same adjacent pair, polarity from odd/even
            res[4:2] = {sel, ~odd};
            res[1:0] = NEG_CHANNEL;
        end
        return res;
    endfunction : decode_mux

    assign sclk_rise = st_reg.sclk_sync[1] && !st_reg.sclk_sync[2];
    assign sclk_fall = !st_reg.sclk_sync[1] && st_reg.sclk_sync[2];
    assign cs_high   = st_reg.cs_sync[1];

    // Next-state logic
    always_comb begin
        logic [7:0] routing;
        logic [7:0] decided;
        routing = 8'h00;
        decided = CODE_ZERO;
        st_next = st_reg;
        st_next.push = 1'b0;
        // Synchronisers; first stages feed only second stages
        st_next.cs_sync   = {st_reg.cs_sync[0], chip_select_n_in};
        st_next.sclk_sync = {st_reg.sclk_sync[1:0], serial_clk_in};
        st_next.din_sync  = {st_reg.din_sync[0], serial_in_in};
        st_next.se_sync   = {st_reg.se_sync[0], lsb_shift_enable_n_in};
        st_next.cmp_sync  = {st_reg.cmp_sync[0], comparator_in};
        if (cs_high) begin
            // Select high clears all but the synchronisers, routing and result word, and releases the pins
            st_next.state     = ST_IDLE;
            st_next.addr_cnt  = CNT3_ZERO;
            st_next.addr_word = WORD_ZERO;
            st_next.mux_en    = 1'b0;
            st_next.trial     = CODE_ZERO;
            st_next.mask      = CODE_ZERO;
            st_next.bit_cnt   = CNT4_ZERO;
            st_next.out_sreg  = SREG_ZERO;
            st_next.dout      = 1'b0;
            st_next.dout_oe_n = 1'b1;
            st_next.conversion_active      = 1'b0;
        end else begin
            case (st_reg.state)
                ST_IDLE: begin
                    // Low samples before the start bit are skipped
                    // Start waits for buffer room so no result is lost
                    if (sclk_rise && st_reg.din_sync[1] && fifo_ready) begin
                        st_next.state    = ST_ADDR;
                        st_next.addr_cnt = CNT3_ZERO;
                    end
                end
                ST_ADDR: begin
                    if (sclk_rise) begin
                        // Sampled while output still released
                        st_next.addr_word = {st_reg.addr_word[2:0], st_reg.din_sync[1]};
                        st_next.addr_cnt  = st_reg.addr_cnt + 3'h1;
                        if (st_reg.addr_cnt == ADDR_LAST) begin
                            // Final word bit taken: latch and go
                            routing          = decode_mux({st_reg.addr_word[2:0],
                                                           st_reg.din_sync[1]});
                            st_next.pos_ch   = routing[7:5];
                            st_next.neg_ch   = routing[4:2];
                            st_next.neg_mode = routing[1:0];
                            st_next.mux_en   = 1'b1;
                            st_next.conversion_active     = 1'b1;
                            st_next.state    = ST_SETTLE;
                        end
                    end
                end
                ST_SETTLE: begin
                    if (sclk_fall) begin
                        // Output leaves release with a leading low
                        st_next.dout      = 1'b0;
                        st_next.dout_oe_n = 1'b0;
                        st_next.trial     = TRIAL_START;
                        st_next.mask      = TRIAL_START;
                        st_next.bit_cnt   = CNT4_ZERO;
                        st_next.state     = ST_CONVERT;
                    end
                end
                ST_CONVERT: begin
                    if (sclk_fall) begin
                        // Comparator low keeps clearing bits: negative above
                        // positive ends as all zeros
                        decided = st_reg.cmp_sync[1] ? st_reg.trial
                                                     : (st_reg.trial & ~st_reg.mask);
                        st_next.dout    = st_reg.cmp_sync[1];
                        st_next.mask    = st_reg.mask >> 1;
                        st_next.trial   = decided | (st_reg.mask >> 1);
                        st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
                        if (st_reg.bit_cnt == LAST_BIT_CNT) begin
                            // Eighth decision ends the conversion
                            st_next.trial     = decided;
                            st_next.conversion_active      = 1'b0;
                            st_next.mux_en    = 1'b0;
                            st_next.out_sreg  = {1'b0, decided};
                            st_next.push      = 1'b1;
                            st_next.push_data = decided;
                            st_next.state     = ST_LSBOUT;
                        end
                    end
                end
                ST_LSBOUT: begin
                    // LSB already on the line; replay starts at bit 1
                    // 8-input shifts only while the control is low
                    if (sclk_fall && (!EIGHT_INPUT || !st_reg.se_sync[1])) begin
                        st_next.out_sreg = st_reg.out_sreg >> 1;
                        st_next.dout     = st_reg.out_sreg[1];
                    end
                end
                default: begin
                    st_next.state = ST_IDLE;
                end
            endcase
        end
    end

    // State register with synchronous reset
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            st_reg.state     <= ST_IDLE;
            st_reg.cs_sync   <= 2'h3;
            st_reg.sclk_sync <= 3'h0;
            st_reg.din_sync  <= 2'h0;
            st_reg.se_sync   <= 2'h3;
            st_reg.cmp_sync  <= 2'h0;
            st_reg.addr_cnt  <= CNT3_ZERO;
            st_reg.addr_word <= WORD_ZERO;
            st_reg.pos_ch    <= CNT3_ZERO;
            st_reg.neg_ch    <= CNT3_ZERO;
            st_reg.neg_mode  <= NEG_CHANNEL;
            st_reg.mux_en    <= 1'b0;
            st_reg.trial     <= CODE_ZERO;
            st_reg.mask      <= CODE_ZERO;
            st_reg.bit_cnt   <= CNT4_ZERO;
            st_reg.out_sreg  <= SREG_ZERO;
            st_reg.dout      <= 1'b0;
            st_reg.dout_oe_n <= 1'b1;
            st_reg.conversion_active      <= 1'b0;
            st_reg.push      <= 1'b0;
            st_reg.push_data <= CODE_ZERO;
        end else begin
            st_reg <= st_next;
        end
    end

    // Result buffer; its ready holds off the next start bit
    result_fifo #(
        .WIDTH (RESULT_BITS),
        .DEPTH (FIFO_WORDS)
    ) u_result_fifo (
        .clock_in     (clock_in),
        .rst_n_in     (rst_n_in),
        .wr_data_in   (st_reg.push_data),
        .wr_valid_in  (st_reg.push),
        .wr_ready_out (fifo_ready),
        .rd_data_out  (result_data_out),
        .rd_valid_out (result_valid_out),
        .rd_ready_in  (result_ready_in)
    );

    // Pin and front-end outputs straight from the state record
    // The result stream comes from the buffer's own storage
    assign serial_out_out             = st_reg.dout;
    assign serial_out_oe_n_out        = st_reg.dout_oe_n;
    assign conversion_active_out      = st_reg.conversion_active;
    assign conversion_active_oe_n_out = st_reg.cs_sync[1];
    assign dac_code_out               = st_reg.trial;
    assign mux_enable_out             = st_reg.mux_en;
    assign pos_channel_out            = st_reg.pos_ch;
    assign neg_channel_out            = st_reg.neg_ch;
    assign neg_mode_out               = st_reg.neg_mode;

    // Checks on the sequencer
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    AST_CS_RELEASE: assert property (
        cs_high |=> (st_reg.dout_oe_n && !st_reg.conversion_active && st_reg.state == ST_IDLE))
        else $error("Select high did not clear and release");

    AST_START_BIT: assert property (
        (st_reg.state == ST_IDLE && !cs_high && sclk_rise && !st_reg.din_sync[1])
        |=> st_reg.state == ST_IDLE)
        else $error("Low sample taken as start bit");

    AST_LATCH_START: assert property (
        (st_reg.state == ST_ADDR && !cs_high && sclk_rise && st_reg.addr_cnt == ADDR_LAST)
        |=> (st_reg.conversion_active && st_reg.mux_en && st_reg.state == ST_SETTLE))
        else $error("Conversion did not start after address word");

    AST_LEADING_LOW: assert property (
        (st_reg.state == ST_SETTLE && !cs_high && sclk_fall)
        |=> (!st_reg.dout && !st_reg.dout_oe_n && st_reg.trial == TRIAL_START))
        else $error("Missing leading low after settling");

    AST_MSB_STREAM: assert property (
        (st_reg.state == ST_CONVERT && !cs_high && sclk_fall)
        |=> st_reg.dout == $past(st_reg.cmp_sync[1]))
        else $error("Decision not driven on serial output");

    AST_EIGHT_PERIODS: assert property (
        (st_reg.state == ST_CONVERT && !cs_high && sclk_fall && st_reg.bit_cnt == LAST_BIT_CNT)
        |=> (!st_reg.conversion_active && st_reg.push && st_reg.state == ST_LSBOUT))
        else $error("Conversion flag did not drop after eight decisions");

    AST_LSB_HOLD: assert property (
        (EIGHT_INPUT && st_reg.state == ST_LSBOUT && !cs_high && st_reg.se_sync[1])
        |=> $stable(st_reg.dout))
        else $error("Serial output moved while shift control high");

    AST_INPUT_IGNORED: assert property (
        (st_reg.state != ST_ADDR) |=> $stable(st_reg.addr_word) || $past(cs_high))
        else $error("Address register changed outside addressing");

    AST_ADJACENT_PAIR: assert property (
        (st_reg.mux_en && st_reg.neg_mode == NEG_CHANNEL)
        |-> (st_reg.pos_ch[2:1] == st_reg.neg_ch[2:1] && st_reg.pos_ch[0] != st_reg.neg_ch[0]))
        else $error("Differential pair not adjacent");

    AST_ZERO_CODE: assert property (
        (st_reg.state == ST_CONVERT && !cs_high && sclk_fall && !st_reg.cmp_sync[1])
        |=> (st_reg.trial & ($past(st_reg.mask))) == CODE_ZERO)
        else $error("Bit kept although positive input below trial");

    // Replay, routing and release checks; the shift check compares
    // against the register bit held in the cycle that sees the falling edge
    AST_REPLAY_SHIFT: assert property (
        (st_reg.state == ST_LSBOUT && !cs_high && sclk_fall
            && (!EIGHT_INPUT || !st_reg.se_sync[1]))
        |=> st_reg.dout == $past(st_reg.out_sreg[1]))
        else $error("Replay bit out of order");

    AST_NEG_SOURCE: assert property (
        (st_reg.mux_en && st_reg.neg_mode != NEG_CHANNEL)
        |-> st_reg.neg_mode == (EIGHT_INPUT ? NEG_COMMON : NEG_GROUND))
        else $error("Wrong negative terminal source");

    AST_FOUR_RANGE: assert property (
        (!EIGHT_INPUT && st_reg.mux_en)
        |-> (!st_reg.pos_ch[2] && !st_reg.neg_ch[2]))
        else $error("Four-input routing outside inputs 0 to 3");

    AST_RELEASED_ADDR: assert property (
        (st_reg.state == ST_IDLE || st_reg.state == ST_ADDR)
        |-> st_reg.dout_oe_n)
        else $error("Output driven while input sampled");

    // Scenarios worth seeing: a result, a shift, a full buffer, an abort
    CVR_RESULT_PUSHED: cover property (st_reg.push);

    CVR_LSB_SHIFT: cover property (st_reg.state == ST_LSBOUT && sclk_fall && !st_reg.se_sync[1]);

    CVR_BUFFER_FULL: cover property (!fifo_ready);

    CVR_ABORT: cover property (st_reg.state == ST_CONVERT && cs_high);

endmodule : serial_sar_adc_interface

// ==== tb/link_controller_model.sv ====
// Controller model: select, link clock and serial input toward the converter
`timescale 1ns/10ps
module link_controller_model (
    // Pins toward the converter
    input  wire logic clock_in,
    input  wire logic serial_out_in,
    input  wire logic serial_out_b_in,
    output logic      cs_n_out,
    output logic      sclk_out,
    output logic      sdi_out,
    output logic      shift_n_out
);
    localparam int HALF = 6; // Link half period, above the 3-cycle minimum
    // Idle pins: select high, link clock parked low
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        sdi_out = 1'b0;
        shift_n_out = 1'b1;
    end
    // Wait n system edges, then step just off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
        #2;
    endtask : tick
    // One addressing bit, held across the rising edge
    task automatic send_bit(input logic d);
        sdi_out = d;
        tick(HALF);
        sclk_out = 1'b1;
        tick(HALF);
        sclk_out = 1'b0;
    endtask : send_bit
    // Whole frame: idle zeros, start bit, word, then 16 output samples
    task automatic convert(input logic [3:0] word, input int lead, output logic [15:0] bits,
        output logic [15:0] bits_b);
        cs_n_out = 1'b0;
        tick(HALF);
        repeat (lead) send_bit(1'b0);
        send_bit(1'b1);
        for (int i = 3; i >= 0; i--) send_bit(word[i]);
        for (int i = 15; i >= 0; i--) begin
            tick(HALF);
            bits[i] = serial_out_in; // Sampled late in the low half, output settled
            bits_b[i] = serial_out_b_in; // Four-input unit runs one period ahead
            sdi_out = ~sdi_out; // Keeps toggling so a stray capture shows
            if (i == 6) shift_n_out = 1'b0; // LSB held one edge, then shift
            sclk_out = 1'b1;
            tick(HALF);
            sclk_out = 1'b0;
        end
    endtask : convert
    // Raise select between frames; link clock stands still
    task automatic release_cs();
        cs_n_out = 1'b1;
        shift_n_out = 1'b1;
        tick(HALF);
    endtask : release_cs
endmodule : link_controller_model

// ==== tb/serial_sar_adc_interface_bench.sv ====
// Self-checking bench for the serial converter control block
`timescale 1ns/10ps
module serial_sar_adc_interface_bench;
    import sar_link_pkg::*;
    // Clock, reset and pins
    logic       clock_in = 1'b0;
    logic       rst_n = 1'b0;
    logic       cs_n, sclk, sdi, shift_n, sdo, sdo_oe_n, active, active_oe_n;
    logic       comp, mux_en, rvalid, rready = 1'b0;
    logic [7:0] dac, rdata, level = 8'h00;
    logic [2:0] pos, neg, cap_pos, cap_neg;
    logic [1:0] negm, cap_mode;
    logic       sdo_b, sdo_b_oe_n, act_b, comp_b, mux_b, rvalid_b; // Four-input unit
    logic [7:0] dac_b, rdata_b;
    logic [2:0] pos_b, neg_b, cap_pos_b, cap_neg_b;
    logic [1:0] negm_b, cap_mode_b;
    logic       seen_active = 1'b0; // Conversion flag seen during a frame
    int         err_total = 0;
    int         comparisons = 0;
    logic [7:0] exp_q[$];           // Results expected from the buffer
    // 40 MHz clock
    always #12.5 clock_in = ~clock_in;
    // Comparator: positive input above trial code; level 0 never wins
    assign comp = (dac < level);
    assign comp_b = (dac_b < level);
    // Remember the flag and the multiplexer choice of each frame
    always @(posedge clock_in) begin
        if (active === 1'b1) seen_active <= 1'b1;
        if (mux_en === 1'b1) begin
            cap_pos <= pos;
            cap_neg <= neg;
            cap_mode <= negm;
        end
        if (mux_b === 1'b1) begin
            cap_pos_b <= pos_b;
            cap_neg_b <= neg_b;
            cap_mode_b <= negm_b;
        end
    end
    // Released outputs read high, as through a pull-up
    link_controller_model ctl_u (.clock_in(clock_in), .serial_out_in(sdo_oe_n ? 1'b1 : sdo),
        .serial_out_b_in(sdo_b_oe_n ? 1'b1 : sdo_b), .cs_n_out(cs_n),
        .sclk_out(sclk), .sdi_out(sdi), .shift_n_out(shift_n));
    serial_sar_adc_interface dut_u (.clock_in(clock_in), .rst_n_in(rst_n),
        .chip_select_n_in(cs_n), .serial_clk_in(sclk), .serial_in_in(sdi),
        .lsb_shift_enable_n_in(shift_n), .serial_out_out(sdo), .serial_out_oe_n_out(sdo_oe_n),
        .conversion_active_out(active), .conversion_active_oe_n_out(active_oe_n),
        .comparator_in(comp), .dac_code_out(dac), .mux_enable_out(mux_en),
        .pos_channel_out(pos), .neg_channel_out(neg), .neg_mode_out(negm),
        .result_data_out(rdata), .result_valid_out(rvalid), .result_ready_in(rready));
    // Four-input unit on the same link, one link period ahead
    serial_sar_adc_interface #(.EIGHT_INPUT(1'b0)) dut_u4 (.clock_in(clock_in),
        .rst_n_in(rst_n), .chip_select_n_in(cs_n), .serial_clk_in(sclk), .serial_in_in(sdi),
        .lsb_shift_enable_n_in(shift_n), .serial_out_out(sdo_b),
        .serial_out_oe_n_out(sdo_b_oe_n), .conversion_active_out(act_b),
        .conversion_active_oe_n_out(), .comparator_in(comp_b), .dac_code_out(dac_b),
        .mux_enable_out(mux_b), .pos_channel_out(pos_b), .neg_channel_out(neg_b),
        .neg_mode_out(negm_b), .result_data_out(rdata_b), .result_valid_out(rvalid_b),
        .result_ready_in(rready));
    // Compare tasks: stream, code, flag
    task automatic chk_stream(input string what, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask : chk_stream
    task automatic chk_code(input string what, input logic [7:0] e, input logic [7:0] g);
        chk_stream(what, {8'h00, e}, {8'h00, g});
    endtask : chk_code
    task automatic chk_flag(input string what, input logic e, input logic g);
        chk_stream(what, {15'h0, e}, {15'h0, g});
    endtask : chk_flag
    // Every word once per half, buffer stalled until full, then one refused start
    task automatic fill_test();
        logic [15:0] got;
        logic [15:0] got_b;
        logic [7:0]  code;
        logic [3:0]  w;
        for (int i = 0; i < FIFO_WORDS; i++) begin
            w = i[3:0];
            level = 8'(i * 11);
            code = (level == 8'h00) ? 8'h00 : level - 8'h01;
            seen_active = 1'b0;
            ctl_u.convert(w, i % 3, got, got_b);
            chk_stream("stream", {1'b0, code, code[0], code[1], code[2], code[3], code[4],
                code[5], code[6]}, got);
            chk_flag("started", 1'b1, seen_active);
            chk_flag("ended", 1'b0, active);
            chk_code("pos input", {5'h00, w[1:0], w[2]}, {5'h00, cap_pos});
            chk_code("neg source", {6'h00, w[3] ? NEG_COMMON : NEG_CHANNEL},
                {6'h00, cap_mode});
            if (!w[3]) chk_code("neg input", {5'h00, w[1:0], ~w[2]}, {5'h00, cap_neg});
            chk_stream("stream b", {code, code[1], code[2], code[3], code[4], code[5], code[6],
                code[7], 1'b0}, got_b);
            chk_flag("ended b", 1'b0, act_b);
            chk_code("pos b", {6'h00, w[1], w[2]}, {5'h00, cap_pos_b});
            chk_code("neg source b", {6'h00, w[3] ? NEG_GROUND : NEG_CHANNEL},
                {6'h00, cap_mode_b});
            if (!w[3]) chk_code("neg b", {6'h00, w[1], ~w[2]}, {5'h00, cap_neg_b});
            exp_q.push_back(code);
            ctl_u.release_cs();
            chk_flag("released", 1'b1, sdo_oe_n);
            chk_flag("released b", 1'b1, sdo_b_oe_n);
            chk_flag("flag released", 1'b1, active_oe_n);
        end
        // Start bit while the buffer is full must not begin a conversion
        seen_active = 1'b0;
        ctl_u.convert(4'h0, 0, got, got_b);
        ctl_u.release_cs();
        chk_flag("start while full", 1'b0, seen_active);
        $display("fill_test done");
    endtask : fill_test
    // Drain the buffer in order until it is empty
    task automatic drain_test();
        int n;
        logic [7:0] code;
        for (int i = 0; i < FIFO_WORDS; i++) begin
            n = 0;
            while (rvalid !== 1'b1 && n < 50) begin
                @(posedge clock_in);
                #2;
                n++;
            end
            code = exp_q.pop_front();
            chk_code("buffered result", code, rdata);
            chk_code("buffered result b", code, rdata_b);
            rready = 1'b1;
            @(posedge clock_in);
            #2;
            rready = 1'b0;
            @(posedge clock_in);
            #2;
        end
        chk_flag("buffer empty", 1'b0, rvalid);
        chk_flag("buffer empty b", 1'b0, rvalid_b);
        $display("drain_test done");
    endtask : drain_test
    // Verdict and end of run
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results
    // Watchdog: frames take some 9k cycles, so 60k means a hang
    initial begin
        repeat (60000) @(posedge clock_in);
        err_total++;
        $display("Error watchdog expected done seen timeout");
        results();
    end
    // Main sequence: reset four cycles, settle synchronisers, run tests
    initial begin
        repeat (4) @(posedge clock_in);
        #2;
        rst_n = 1'b1;
        repeat (3) @(posedge clock_in);
        #2;
        fill_test();
        drain_test();
        results();
    end
endmodule : serial_sar_adc_interface_bench
